// ---- design/vip_event_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module vip_event_sync #(
  parameter int               WIDTH     = 64,
  parameter logic [WIDTH-1:0] CONNECTED = '1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] src_async,
  output logic      [WIDTH-1:0] evt_pulse
);

  if (WIDTH < 1) begin : g_bad_width
    $error("vip_event_sync: WIDTH must be at least 1");
  end

  // ---------------------------------------------------------------
  // Per-channel synchroniser and rising-edge detector
  // ---------------------------------------------------------------
  // Unconnected channels are tied off so they never raise an event;
  // flops live per channel so no vector has two kinds of driver
  for (genvar i = 0; i < WIDTH; i++) begin : g_chan
    if (CONNECTED[i]) begin : g_live
      logic meta_q;
      logic sync_q;
      logic prev_q;
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          meta_q <= src_async[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign evt_pulse[i] = sync_q & ~prev_q;
    end else begin : g_tied
      assign evt_pulse[i] = 1'b0;
    end
  end

endmodule : vip_event_sync

`default_nettype wire

// ---- design/vip_intc.sv ----
`timescale 1ns/1ps
`default_nettype none

module vip_intc #(
  parameter int                      NUM_CH    = 64,
  parameter logic [NUM_CH-1:0]       CONNECTED = '1
) (
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  input  wire logic [NUM_CH-1:0]                       irq_src,
  input  wire logic [NUM_CH-1:0]                       channel_enable,
  input  wire logic [NUM_CH-1:0][vip_pkg::PRIO_W-1:0]  channel_priority_regs,
  input  wire vip_pkg::vip_cfg_t                       cfg,
  input  wire logic [NUM_CH-1:0]                       fast_status_clr,
  input  wire logic [NUM_CH-1:0]                       normal_status_clr,
  output logic      [NUM_CH-1:0]                       fast_pending_status,
  output logic      [NUM_CH-1:0]                       normal_pending_status,
  output logic                                         fast_irq,
  output logic                                         normal_irq,
  output logic      [vip_pkg::ADDR_W-1:0]              fast_vector_addr,
  output logic      [vip_pkg::ADDR_W-1:0]              normal_vector_addr
);
  import vip_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (NUM_CH < 2 || NUM_CH > NUM_CHANNELS) begin : g_bad_ch
    $error("vip_intc: NUM_CH must lie in 2..64");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] evt;
  logic [NUM_CH-1:0] fast_route;
  logic [NUM_CH-1:0] fast_set;
  logic [NUM_CH-1:0] normal_set;
  logic [NUM_CH-1:0] fast_pend_q;
  logic [NUM_CH-1:0] fast_pend_d;
  logic [NUM_CH-1:0] normal_pend_q;
  logic [NUM_CH-1:0] normal_pend_d;
  logic [NUM_CH-1:0] pend_any;
  logic [NUM_CH-1:0] eff_en_q;
  logic [NUM_CH-1:0] eff_en_d;
  logic [NUM_CH-1:0] en_use;
  logic [NUM_CH-1:0] fast_qual;
  logic [NUM_CH-1:0] normal_qual;
  logic              deferred;
  logic              fast_raw;
  logic              normal_raw;
  vip_win_t          fast_win;
  vip_win_t          normal_win;
  logic [ADDR_W-1:0] base_addr;
  logic [ADDR_W-1:0] fast_vec_d;
  logic [ADDR_W-1:0] normal_vec_d;
  logic              fast_irq_q;
  logic              normal_irq_q;
  logic [ADDR_W-1:0] fast_vec_q;
  logic [ADDR_W-1:0] normal_vec_q;

  assign deferred   = cfg.controller_options[OPT_DEFERRED];
  assign fast_raw   = cfg.controller_options[OPT_FAST_UNMASKED];
  assign normal_raw = cfg.controller_options[OPT_NORMAL_UNMASKED];
  assign base_addr  = {cfg.vector_table_base, {BASE_LSB{1'b0}}};

  // ---------------------------------------------------------------
  // Input capture
  // ---------------------------------------------------------------
  vip_event_sync #(
    .WIDTH     (NUM_CH),
    .CONNECTED (CONNECTED)
  ) u_sync (
    .clk       (clk),
    .rst       (rst),
    .src_async (irq_src),
    .evt_pulse (evt)
  );

  // ---------------------------------------------------------------
  // Routing by priority
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_route
    if (i == 0) begin : g_nmi
      assign fast_route[i] = 1'b1;
      assign en_use[i]     = 1'b1;
    end else begin : g_norm
      assign fast_route[i] = channel_priority_regs[i] < FAST_PRIO_LIMIT;
      // Deferred mode freezes the enable seen by the prioritizer
      assign en_use[i]     = deferred ? eff_en_q[i] : channel_enable[i];
    end
  end

  assign fast_set   = evt & fast_route;
  assign normal_set = evt & ~fast_route;

  // ---------------------------------------------------------------
  // Pending status
  // ---------------------------------------------------------------
  // A new event beats a clear landing in the same cycle
  assign fast_pend_d   = (fast_pend_q & ~fast_status_clr) | fast_set;
  assign normal_pend_d = (normal_pend_q & ~normal_status_clr) | normal_set;
  assign pend_any      = fast_pend_q | normal_pend_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      fast_pend_q   <= PEND_RESET[NUM_CH-1:0];
      normal_pend_q <= PEND_RESET[NUM_CH-1:0];
    end else begin
      fast_pend_q   <= fast_pend_d;
      normal_pend_q <= normal_pend_d;
    end
  end

  // ---------------------------------------------------------------
  // Deferred enable latch
  // ---------------------------------------------------------------
  // While a channel has an event pending its enable is held; it only
  // follows the software bit once the event has been cleared.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_eff
    assign eff_en_d[i] = pend_any[i] ? eff_en_q[i] : channel_enable[i];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      eff_en_q <= EFF_RESET[NUM_CH-1:0];
    end else if (deferred) begin
      eff_en_q <= eff_en_d;
    end else begin
      eff_en_q <= channel_enable;
    end
  end

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  assign fast_qual   = fast_pend_q & (fast_raw ? {NUM_CH{1'b1}} : en_use);
  assign normal_qual = normal_pend_q & (normal_raw ? {NUM_CH{1'b1}} : en_use);

  // Scan upward and replace only on strictly better priority, so the
  // smallest channel number keeps a tie.
  function automatic vip_win_t pick(
    input logic [NUM_CH-1:0]              qual,
    input logic [NUM_CH-1:0][PRIO_W-1:0]  prio
  );
    vip_win_t          w;
    logic [PRIO_W-1:0] best;
    w    = '0;
    best = PRIO_LOWEST;
    for (int i = 0; i < NUM_CH; i++) begin
      if (qual[i] && (!w.found || prio[i] < best)) begin
        w.found = 1'b1;
        w.chan  = CHAN_W'(i);
        best    = prio[i];
      end
    end
    return w;
  endfunction : pick

  // Channel 0 is fast whatever its priority field says, so it ranks top
  function automatic logic [NUM_CH-1:0][PRIO_W-1:0] eff_prio(
    input logic [NUM_CH-1:0][PRIO_W-1:0] prio
  );
    logic [NUM_CH-1:0][PRIO_W-1:0] p;
    p    = prio;
    p[0] = '0;
    return p;
  endfunction : eff_prio

  logic [NUM_CH-1:0][PRIO_W-1:0] prio_eff;
  assign prio_eff   = eff_prio(channel_priority_regs);
  assign fast_win   = pick(fast_qual, prio_eff);
  assign normal_win = pick(normal_qual, channel_priority_regs);

  // ---------------------------------------------------------------
  // Vector address
  // ---------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] vec(
    input vip_win_t          w,
    input logic [ADDR_W-1:0] base,
    input logic [SIZE_W-1:0] size
  );
    logic [ADDR_W-1:0] idx;
    idx = {{(ADDR_W-CHAN_W){1'b0}}, w.chan} + ADDR_W'(1);
    if (!w.found) begin
      return base;
    end
    return base + (idx << (ENTRY_UNIT_SHIFT + int'(size)));
  endfunction : vec

  assign fast_vec_d   = vec(fast_win, base_addr, cfg.entry_size);
  assign normal_vec_d = vec(normal_win, base_addr, cfg.entry_size);

  // Recomputed every cycle; a clear or a new event shows two cycles later
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_vec_q   <= ADDR_RESET;
      normal_vec_q <= ADDR_RESET;
    end else begin
      fast_vec_q   <= fast_vec_d;
      normal_vec_q <= normal_vec_d;
    end
  end

  // ---------------------------------------------------------------
  // Core interrupt lines
  // ---------------------------------------------------------------
  // Unmasked-vector bits never raise a line; only enabled events and channel 0 events do
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_irq_q   <= 1'b0;
      normal_irq_q <= 1'b0;
    end else begin
      fast_irq_q   <= |(fast_pend_q & en_use);
      normal_irq_q <= |(normal_pend_q & en_use);
    end
  end

  assign fast_pending_status   = fast_pend_q;
  assign normal_pending_status = normal_pend_q;
  assign fast_irq              = fast_irq_q;
  assign normal_irq            = normal_irq_q;
  assign fast_vector_addr      = fast_vec_q;
  assign normal_vector_addr    = normal_vec_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] w_fast_better;

  // Any qualifying fast channel that should outrank the winner
  for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
    assign w_fast_better[i] = fast_qual[i] && fast_win.found && (
      (prio_eff[i] < prio_eff[fast_win.chan]) ||
      (prio_eff[i] == prio_eff[fast_win.chan] && CHAN_W'(i) < fast_win.chan));
  end

  sequence s_deferred_two;
    deferred ##1 deferred;
  endsequence

  sequence s_quiet_fast;
    (fast_pend_q == '0) [*2];
  endsequence

  a_route_fast_set: assert property (@(posedge clk) disable iff (rst)
    (fast_set != '0) |=> ((fast_pend_q & $past(fast_set)) == $past(fast_set)))
    else $error("fast-routed event not latched in fast status");

  a_route_normal_set: assert property (@(posedge clk) disable iff (rst)
    (normal_set != '0) |=> ((normal_pend_q & $past(normal_set)) == $past(normal_set))
                          && ((fast_pend_q & $past(normal_set & ~fast_pend_q)) == '0))
    else $error("normal-routed event misrouted");

  a_status_no_rise: assert property (@(posedge clk) disable iff (rst)
    ((fast_pend_q & ~$past(fast_pend_q | fast_set)) == '0)
    && ((normal_pend_q & ~$past(normal_pend_q | normal_set)) == '0))
    else $error("status bit set without an event");

  a_w1c_clear: assert property (@(posedge clk) disable iff (rst)
    ((fast_status_clr & ~fast_set) != '0)
    |=> ((fast_pend_q & $past(fast_status_clr & ~fast_set)) == '0))
    else $error("write-one clear did not clear status");

  a_nmi_fast: assert property (@(posedge clk) disable iff (rst)
    evt[0] |=> fast_pend_q[0] ##1 (fast_irq || $past(fast_status_clr[0])))
    else $error("channel 0 event did not reach fast line");

  a_idle_base: assert property (@(posedge clk) disable iff (rst)
    !fast_win.found |=> (fast_vector_addr == $past(base_addr)))
    else $error("idle fast vector differs from table base");

  a_winner_best: assert property (@(posedge clk) disable iff (rst)
    fast_win.found |-> (fast_qual[fast_win.chan] && w_fast_better == '0))
    else $error("fast winner is not the best qualifying channel");

  a_line_quiet: assert property (@(posedge clk) disable iff (rst)
    s_quiet_fast |-> !fast_irq)
    else $error("fast line high with nothing pending");

  a_deferred_hold: assert property (@(posedge clk) disable iff (rst)
    s_deferred_two |-> (((eff_en_q ^ $past(eff_en_q)) & $past(pend_any)) == '0))
    else $error("deferred enable changed while event pending");

  a_vector_size: assert property (@(posedge clk) disable iff (rst)
    (normal_win.found && cfg.entry_size == SIZE_32B)
    |=> (normal_vector_addr
         == $past(base_addr) + {$past(normal_win.chan), 5'h00} + ADDR_W'(32)))
    else $error("normal vector ignores entry size");

  a_normal_idle_base: assert property (@(posedge clk) disable iff (rst)
    !normal_win.found |=> (normal_vector_addr == $past(base_addr)))
    else $error("idle normal vector differs from table base");

  a_fast_vector_size: assert property (@(posedge clk) disable iff (rst)
    (fast_win.found && cfg.entry_size == SIZE_8B)
    |=> (fast_vector_addr
         == $past(base_addr) + {$past(fast_win.chan), 3'h0} + ADDR_W'(8)))
    else $error("fast vector ignores entry size");

  a_normal_drop: assert property (@(posedge clk) disable iff (rst)
    (!deferred && ((normal_pend_q & channel_enable) == '0)) |=> !normal_irq)
    else $error("normal line high with no enabled event");

  a_fast_drop: assert property (@(posedge clk) disable iff (rst)
    (!deferred && ((fast_pend_q & {channel_enable[NUM_CH-1:1], 1'b1}) == '0))
    |=> !fast_irq)
    else $error("fast line high with no enabled event");

  a_nmi_never_normal: assert property (@(posedge clk) disable iff (rst)
    !normal_pend_q[0])
    else $error("channel 0 reached normal status");

  a_tied_quiet: assert property (@(posedge clk) disable iff (rst)
    (((fast_pend_q | normal_pend_q) & ~CONNECTED) == '0))
    else $error("unconnected channel set a status bit");

endmodule : vip_intc

`default_nettype wire

// ---- design/vip_pkg.sv ----
package vip_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CHANNELS  = 64;
  localparam int CHAN_W        = 6;
  localparam int PRIO_W        = 3;
  localparam int ADDR_W        = 29;
  localparam int BASE_W        = 26;
  localparam int BASE_LSB      = 3;
  localparam int SIZE_W        = 2;

  // ---------------------------------------------------------------
  // Option bits and encodings
  // ---------------------------------------------------------------
  localparam int OPT_FAST_UNMASKED   = 0;
  localparam int OPT_NORMAL_UNMASKED = 1;
  localparam int OPT_DEFERRED        = 2;
  localparam int OPT_W               = 3;

  localparam logic [PRIO_W-1:0] FAST_PRIO_LIMIT = 3'h2;
  localparam logic [PRIO_W-1:0] PRIO_LOWEST     = 3'h7;
  localparam logic [CHAN_W-1:0] NMI_CHANNEL     = 6'h00;

  // Entry size code is a left shift of the 4-byte unit
  localparam logic [SIZE_W-1:0] SIZE_4B  = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_8B  = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_16B = 2'h2;
  localparam logic [SIZE_W-1:0] SIZE_32B = 2'h3;
  localparam int               ENTRY_UNIT_SHIFT = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [NUM_CHANNELS-1:0] PEND_RESET = 64'h0;
  localparam logic [NUM_CHANNELS-1:0] EFF_RESET  = 64'h0;
  localparam logic [ADDR_W-1:0]       ADDR_RESET = 29'h0;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [BASE_W-1:0] vector_table_base;
    logic [SIZE_W-1:0] entry_size;
    logic [OPT_W-1:0]  controller_options;
  } vip_cfg_t;

  typedef struct packed {
    logic              found;
    logic [CHAN_W-1:0] chan;
  } vip_win_t;

endpackage : vip_pkg

// ---- test/vip_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module vip_core_model (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     service_en,
  input  wire vip_pkg::vip_cfg_t        cfg,
  input  wire logic                     fast_irq,
  input  wire logic                     normal_irq,
  input  wire logic [vip_pkg::ADDR_W-1:0] fast_vector_addr,
  input  wire logic [vip_pkg::ADDR_W-1:0] normal_vector_addr,
  output logic      [63:0]              fast_status_clr,
  output logic      [63:0]              normal_status_clr,
  output int                            serviced
);
  import vip_pkg::*;

  logic [ADDR_W-1:0] offs;
  logic [CHAN_W-1:0] chan;
  int                hold;

  // ---------------------------------------------------------------
  // Service routine: read vector, decode handler, acknowledge
  // ---------------------------------------------------------------
  always_comb begin
    offs = (fast_irq ? fast_vector_addr : normal_vector_addr) - {cfg.vector_table_base, 3'h0};
    chan = CHAN_W'((offs >> (ENTRY_UNIT_SHIFT + int'(cfg.entry_size))) - 1);
  end

  always_ff @(posedge clk) begin
    fast_status_clr   <= '0;
    normal_status_clr <= '0;
    if (rst) begin
      hold     <= 0;
      serviced <= 0;
    end else if (hold != 0) begin
      hold <= hold - 1;
    end else if (service_en && (fast_irq || normal_irq)) begin
      // Fast line first, as the core would take it first
      if (fast_irq) begin
        fast_status_clr[chan] <= 1'b1;
      end else begin
        normal_status_clr[chan] <= 1'b1;
      end
      // Wait out the clear and the vector update before reading again
      hold     <= 3;
      serviced <= serviced + 1;
    end
  end
endmodule : vip_core_model

`default_nettype wire

// ---- test/vip_intc_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module vip_intc_tb;
  import vip_pkg::*;

  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic [63:0]           irq_src = '0;
  logic [63:0]           en = '0;
  logic [63:0][2:0]      prio = '0;
  vip_cfg_t              cfg;
  logic [63:0]           tb_fclr = '0;
  logic [63:0]           tb_nclr = '0;
  logic [63:0]           m_fclr;
  logic [63:0]           m_nclr;
  logic [63:0]           fst;
  logic [63:0]           nst;
  logic [63:0]           nst_b;
  logic                  firq;
  logic                  nirq;
  logic [ADDR_W-1:0]     fva;
  logic [ADDR_W-1:0]     nva;
  logic                  svc = 1'b0;
  int                    serviced;
  int                    num_errors = 0;
  int                    checks_done = 0;

  always #5 clk = ~clk;

  vip_intc i_vip_intc (.clk(clk), .rst(rst), .irq_src(irq_src), .channel_enable(en),
    .channel_priority_regs(prio), .cfg(cfg), .fast_status_clr(tb_fclr | m_fclr),
    .normal_status_clr(tb_nclr | m_nclr), .fast_pending_status(fst),
    .normal_pending_status(nst), .fast_irq(firq), .normal_irq(nirq),
    .fast_vector_addr(fva), .normal_vector_addr(nva));

  // Top channel left unconnected to prove it stays silent
  vip_intc #(.CONNECTED({1'b0, {63{1'b1}}})) i_vip_intc_nc (.clk(clk), .rst(rst),
    .irq_src(irq_src), .channel_enable(en), .channel_priority_regs(prio), .cfg(cfg),
    .fast_status_clr(tb_fclr), .normal_status_clr(tb_nclr), .fast_pending_status(),
    .normal_pending_status(nst_b), .fast_irq(), .normal_irq(),
    .fast_vector_addr(), .normal_vector_addr());

  vip_core_model i_vip_core_model (.clk(clk), .rst(rst), .service_en(svc), .cfg(cfg),
    .fast_irq(firq), .normal_irq(nirq), .fast_vector_addr(fva),
    .normal_vector_addr(nva), .fast_status_clr(m_fclr), .normal_status_clr(m_nclr),
    .serviced(serviced));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // ch = -1 gives the bare table base
  function automatic logic [63:0] vec(input int ch);
    return 64'({cfg.vector_table_base, 3'h0} + (29'(ch + 1) << (2 + cfg.entry_size)));
  endfunction : vec

  // Edge, then six cycles covers sync, status, line and vector
  task automatic fire(input int ch, input logic [2:0] p);
    prio[ch]    = p;
    irq_src[ch] = 1'b1;
    tick(6);
    irq_src[ch] = 1'b0;
    tick(1);
  endtask : fire

  task automatic nclr(input int ch);
    tb_nclr[ch] = 1'b1;
    tick(1);
    tb_nclr = '0;
    tick(2);
  endtask : nclr

  task automatic clr_all();
    tb_fclr = '1;
    tb_nclr = '1;
    tick(1);
    tb_fclr = '0;
    tb_nclr = '0;
    tick(3);
  endtask : clr_all

  task automatic wrap_up();
    $display("checks_done %0d num_errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    cfg = '{vector_table_base: 26'h0123456, entry_size: SIZE_4B, controller_options: 3'h0};
    tick(5);
    rst = 1'b0;
    tick(2);
    chk("normal_vector_addr", vec(-1), 64'(nva));
    chk("fast_vector_addr", vec(-1), 64'(fva));
    en = '1;
    for (int s = 0; s < 4; s++) begin
      cfg.entry_size = 2'(s);
      fire(5, 3'h4);
      chk("normal_vector_addr", vec(5), 64'(nva));
      fire(9, 3'h3);
      chk("normal_vector_addr", vec(9), 64'(nva));
      chk("normal_irq", 64'h1, 64'(nirq));
      chk("fast_pending_status", 64'h0, fst);
      clr_all();
    end
    cfg.entry_size = SIZE_8B;
    fire(7, 3'h2);
    fire(3, 3'h2);
    chk("normal_vector_addr", vec(3), 64'(nva));
    nclr(3);
    chk("normal_vector_addr", vec(7), 64'(nva));
    chk("normal_pending_status", 64'h80, nst);
    clr_all();
    fire(12, 3'h1);
    fire(20, 3'h0);
    chk("fast_vector_addr", vec(20), 64'(fva));
    chk("fast_irq", 64'h1, 64'(firq));
    chk("normal_pending_status", 64'h0, nst);
    clr_all();
    en[30] = 1'b0;
    fire(30, 3'h5);
    chk("normal_pending_status", 64'h1 << 30, nst);
    chk("normal_irq", 64'h0, 64'(nirq));
    chk("normal_vector_addr", vec(-1), 64'(nva));
    cfg.controller_options[OPT_NORMAL_UNMASKED] = 1'b1;
    tick(2);
    chk("normal_vector_addr", vec(30), 64'(nva));
    chk("normal_irq", 64'h0, 64'(nirq));
    cfg.controller_options[OPT_NORMAL_UNMASKED] = 1'b0;
    en[30] = 1'b1;
    tick(2);
    chk("normal_irq", 64'h1, 64'(nirq));
    en[30] = 1'b0;
    tick(2);
    chk("normal_irq", 64'h0, 64'(nirq));
    chk("normal_vector_addr", vec(-1), 64'(nva));
    clr_all();
    // Fast-line unmasked vector on a disabled channel
    en[12] = 1'b0;
    fire(12, 3'h1);
    chk("fast_pending_status", 64'h1 << 12, fst);
    chk("fast_vector_addr", vec(-1), 64'(fva));
    cfg.controller_options[OPT_FAST_UNMASKED] = 1'b1;
    tick(2);
    chk("fast_vector_addr", vec(12), 64'(fva));
    chk("fast_irq", 64'h0, 64'(firq));
    cfg.controller_options[OPT_FAST_UNMASKED] = 1'b0;
    clr_all();
    en[12] = 1'b1;
    cfg.controller_options[OPT_DEFERRED] = 1'b1;
    tick(2);
    fire(33, 3'h6);
    en[33] = 1'b0;
    tick(3);
    chk("normal_irq", 64'h1, 64'(nirq));
    chk("normal_vector_addr", vec(33), 64'(nva));
    nclr(33);
    chk("normal_irq", 64'h0, 64'(nirq));
    fire(33, 3'h6);
    en[33] = 1'b1;
    tick(3);
    chk("normal_irq", 64'h0, 64'(nirq));
    nclr(33);
    tick(1);
    fire(33, 3'h6);
    chk("normal_irq", 64'h1, 64'(nirq));
    clr_all();
    cfg.controller_options[OPT_DEFERRED] = 1'b0;
    en[0] = 1'b0;
    fire(0, 3'h7);
    chk("fast_pending_status", 64'h1, fst);
    chk("fast_irq", 64'h1, 64'(firq));
    chk("fast_vector_addr", vec(0), 64'(fva));
    clr_all();
    // Level held high must give a single event only
    prio[45] = 3'h2;
    irq_src[45] = 1'b1;
    tick(6);
    nclr(45);
    tick(4);
    chk("normal_pending_status", 64'h0, nst);
    irq_src[45] = 1'b0;
    fire(63, 3'h2);
    chk("normal_pending_status", 64'h1 << 63, nst);
    chk("normal_pending_status_nc", 64'h0, nst_b);
    clr_all();
    en = '1;
    fire(10, 3'h5);
    fire(11, 3'h2);
    fire(40, 3'h7);
    svc = 1'b1;
    for (int i = 0; i < 60 && serviced != 3; i++) tick(1);
    tick(3);
    chk("serviced", 64'd3, 64'(serviced));
    chk("normal_pending_status", 64'h0, nst);
    chk("normal_vector_addr", vec(-1), 64'(nva));
    wrap_up();
  end
endmodule : vip_intc_tb

`default_nettype wire
